// >>> pkg/dtc_cfg.svh
/*
  Offsets, field positions, reset values and divider counts of the dual timer block.
  Assumes it is included by bare name before any use of its macros.
*/
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// Register addresses in the special function register space.
`define DTC_ADDR_TIMER_CONTROL 8'h88
`define DTC_ADDR_TIMER_MODE_CONTROL 8'h89
`define DTC_ADDR_TL0 8'h8A
`define DTC_ADDR_TL1 8'h8B
`define DTC_ADDR_TH0 8'h8C
`define DTC_ADDR_TH1 8'h8D
`define DTC_ADDR_CKCON 8'h8E
// Bit-address row of the timer control register (bit addresses 88h to 8Fh).
`define DTC_BIT_ROW 5'h11

// Timer control field positions.
`define DTC_TF1 3'h7
`define DTC_TR1 3'h6
`define DTC_TF0 3'h5
`define DTC_TR0 3'h4
`define DTC_IE1 3'h3
`define DTC_IT1 3'h2
`define DTC_IE0 3'h1
`define DTC_IT0 3'h0
// Clock control prescale select positions.
`define DTC_CK_T1M 3'h4
`define DTC_CK_T0M 3'h3

// Reset values and the value of unimplemented locations.
`define DTC_RST_BYTE 8'h00
`define DTC_RST_PIN 1'h1
`define DTC_UNMAPPED 8'hFF

// Internal count clock dividers of the system clock.
`define DTC_DIV_FAST 4
`define DTC_DIV_SLOW 12

`endif

// >>> pkg/dtc_pkg.sv
/*
  Types shared by the dual timer block: mode codes, mode fields, count results, bus request.
  Assumes the register access comes from the core as one request word per cycle.
*/
package dtc_pkg;

  // Mode select codes of one timer.
  typedef enum logic [1:0] {
    DTC_MODE_13BIT = 2'b00,
    DTC_MODE_16BIT = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_type;

  // One nibble of the timer mode control register.
  typedef struct packed {
    logic gate;
    logic count_sel;
    dtc_mode_type mode;
  } dtc_timer_mode_control_field_type;

  // Result of one counting step.
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic ovf;
  } dtc_count_type;

  // Register request from the core: byte read, byte write and single bit write.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_wr;
    logic [7:0] bit_addr;
    logic bit_val;
  } dtc_sfr_req_type;

endpackage

// >>> logic/dtc_timers.sv
/*
  Two timer/counters with their control, mode and clock select registers and the two
  external interrupt flags. Assumes pins and the request word are synchronous to clk,
  and that the interrupt controller pulses a vector acknowledge for each source.
*/
`timescale 1ns/1ps
`include "dtc_cfg.svh"

module dtc_timers #(
  parameter int DIV_FAST = `DTC_DIV_FAST,
  parameter int DIV_SLOW = `DTC_DIV_SLOW
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Power management level from the power control logic.
  input wire logic power_down_request,
  // Register access from the core.
  input wire dtc_pkg::dtc_sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  // Vector acknowledges from the interrupt controller.
  input wire logic timer0_vector_ack,
  input wire logic timer1_vector_ack,
  input wire logic ext_irq0_vector_ack,
  input wire logic ext_irq1_vector_ack,
  // Pins.
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  // Flags towards the interrupt controller.
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic ext_irq0_flag,
  output logic ext_irq1_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter checks.

  // The slow divider must be a whole multiple of the fast one and fit four bits.
  if (DIV_FAST < 1 || DIV_SLOW > 16 || DIV_SLOW < DIV_FAST || (DIV_SLOW % DIV_FAST) != 0)
  begin : g_bad_div
    $error("dtc_timers: divider parameters cannot be served");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.

  // True when the request is a byte write to the given address.
  function automatic logic wr_hit(input dtc_pkg::dtc_sfr_req_type req, input logic [7:0] a);
    wr_hit = req.wr && (req.addr == a);
  endfunction

  // True when the address is one of this block's registers.
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[7:3] == `DTC_BIT_ROW) && (a[2:0] != 3'h7);
  endfunction

  // One counting step of a timer in the given mode; holds when inc is low.
  function automatic dtc_pkg::dtc_count_type dtc_step(input logic inc,
                                                      input dtc_pkg::dtc_mode_type mode,
                                                      input logic [7:0] lo,
                                                      input logic [7:0] hi);
    dtc_pkg::dtc_count_type res;
    logic [5:0] lo5;
    logic [8:0] lo_sum;
    logic [8:0] hi_sum;
    res.low = lo;
    res.high = hi;
    res.ovf = 1'h0;
    lo5 = {1'h0, lo[4:0]} + 6'h01;
    lo_sum = {1'h0, lo} + 9'h001;
    hi_sum = {1'h0, hi} + 9'h001;
    if (inc)
    begin
      unique case (mode)
        dtc_pkg::DTC_MODE_13BIT:
        begin
          res.low = {lo[7:5], lo5[4:0]};
          if (lo5[5])
          begin
            res.high = hi_sum[7:0];
            res.ovf = hi_sum[8];
          end
        end
        dtc_pkg::DTC_MODE_16BIT:
        begin
          res.low = lo_sum[7:0];
          if (lo_sum[8])
          begin
            res.high = hi_sum[7:0];
            res.ovf = hi_sum[8];
          end
        end
        dtc_pkg::DTC_MODE_RELOAD:
        begin
          // Reload from the high byte on rollover.
          res.low = lo_sum[8] ? hi : lo_sum[7:0];
          res.ovf = lo_sum[8];
        end
        dtc_pkg::DTC_MODE_SPLIT:
        begin
          res.low = lo_sum[7:0];
          res.ovf = lo_sum[8];
        end
      endcase
    end
    dtc_step = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic active;
  logic [3:0] slow_reg, slow_next, fast_reg, fast_next;
  logic slow_tick, fast_tick;
  logic t0_prev_reg, t1_prev_reg, irq0_prev_reg, irq1_prev_reg;
  logic [7:0] timer_control_reg, timer_control_next, timer_control_sw;
  logic [7:0] timer_mode_control_reg, timer_mode_control_next;
  logic t0m_reg, t0m_next, t1m_reg, t1m_next;
  logic [7:0] tl0_reg, tl0_next, th0_reg, th0_next;
  logic [7:0] tl1_reg, tl1_next, th1_reg, th1_next;
  logic [7:0] sfr_rdata_reg, sfr_rdata_next;
  dtc_pkg::dtc_timer_mode_control_field_type t0f, t1f;
  dtc_pkg::dtc_count_type cnt0, cnt1;
  logic presc0, presc1, tick0, tick1, run_en0, run_en1, inc0, inc1;
  logic split0, th0_inc, ovf0, ovf1, edge0, edge1;
  logic [8:0] th0_sum;

  // Counting goes on in idle; only power down and the clock enable freeze it.
  assign active = clk_en & ~power_down_request;

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler and pin history.

  // Two aligned dividers give the fast and slow internal count ticks.
  always_comb
  begin
    slow_tick = (slow_reg == 4'(DIV_SLOW - 1));
    fast_tick = (fast_reg == 4'(DIV_FAST - 1));
    slow_next = slow_tick ? 4'h0 : slow_reg + 4'h1;
    fast_next = fast_tick ? 4'h0 : fast_reg + 4'h1;
  end

  // Registers the dividers and the previous pin levels for edge detection.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      slow_reg <= 4'h0;
      fast_reg <= 4'h0;
      t0_prev_reg <= `DTC_RST_PIN;
      t1_prev_reg <= `DTC_RST_PIN;
      irq0_prev_reg <= `DTC_RST_PIN;
      irq1_prev_reg <= `DTC_RST_PIN;
    end
    else if (active)
    begin
      slow_reg <= slow_next;
      fast_reg <= fast_next;
      t0_prev_reg <= timer0_count_pin;
      t1_prev_reg <= timer1_count_pin;
      irq0_prev_reg <= ext_irq0_pin;
      irq1_prev_reg <= ext_irq1_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers and counts.

  // Computes register writes, counting, overflow and external interrupt flags.
  always_comb
  begin
    t0f = dtc_pkg::dtc_timer_mode_control_field_type'(timer_mode_control_reg[3:0]);
    t1f = dtc_pkg::dtc_timer_mode_control_field_type'(timer_mode_control_reg[7:4]);
    // Byte write, then single bit write into the control register.
    timer_control_sw = timer_control_reg;
    if (wr_hit(sfr_req, `DTC_ADDR_TIMER_CONTROL))
      timer_control_sw = sfr_req.wdata;
    if (sfr_req.bit_wr && sfr_req.bit_addr[7:3] == `DTC_BIT_ROW)
      timer_control_sw[sfr_req.bit_addr[2:0]] = sfr_req.bit_val;
    // Count sources.
    presc0 = t0m_reg ? fast_tick : slow_tick;
    presc1 = t1m_reg ? fast_tick : slow_tick;
    tick0 = t0f.count_sel ? (t0_prev_reg & ~timer0_count_pin) : presc0;
    tick1 = t1f.count_sel ? (t1_prev_reg & ~timer1_count_pin) : presc1;
    // Run and gate control.
    run_en0 = timer_control_reg[`DTC_TR0] & (~t0f.gate | ext_irq0_pin);
    run_en1 = timer_control_reg[`DTC_TR1] & (~t1f.gate | ext_irq1_pin);
    inc0 = run_en0 & tick0;
    inc1 = run_en1 & tick1 & (t1f.mode != dtc_pkg::DTC_MODE_SPLIT);
    cnt0 = dtc_step(inc0, t0f.mode, tl0_reg, th0_reg);
    cnt1 = dtc_step(inc1, t1f.mode, tl1_reg, th1_reg);
    // In split mode the timer 0 high byte runs on timer 1's run bit and clock.
    split0 = (t0f.mode == dtc_pkg::DTC_MODE_SPLIT);
    th0_inc = split0 & timer_control_reg[`DTC_TR1] & presc1;
    th0_sum = {1'h0, th0_reg} + 9'h001;
    tl0_next = cnt0.low;
    th0_next = split0 ? (th0_inc ? th0_sum[7:0] : th0_reg) : cnt0.high;
    tl1_next = cnt1.low;
    th1_next = cnt1.high;
    ovf0 = cnt0.ovf;
    ovf1 = split0 ? (th0_inc & th0_sum[8]) : cnt1.ovf;
    // Software writes to count bytes take precedence over counting.
    if (wr_hit(sfr_req, `DTC_ADDR_TL0))
      tl0_next = sfr_req.wdata;
    if (wr_hit(sfr_req, `DTC_ADDR_TH0))
      th0_next = sfr_req.wdata;
    if (wr_hit(sfr_req, `DTC_ADDR_TL1))
      tl1_next = sfr_req.wdata;
    if (wr_hit(sfr_req, `DTC_ADDR_TH1))
      th1_next = sfr_req.wdata;
    // Overflow flags: hardware set wins over a clear in the same cycle.
    timer_control_next = timer_control_sw;
    timer_control_next[`DTC_TF0] = (timer_control_sw[`DTC_TF0] & ~timer0_vector_ack) | ovf0;
    timer_control_next[`DTC_TF1] = (timer_control_sw[`DTC_TF1] & ~timer1_vector_ack) | ovf1;
    // External flags: edge mode latches falling edges, level mode follows the pin.
    edge0 = irq0_prev_reg & ~ext_irq0_pin;
    edge1 = irq1_prev_reg & ~ext_irq1_pin;
    timer_control_next[`DTC_IE0] = timer_control_reg[`DTC_IT0] ?
      ((timer_control_sw[`DTC_IE0] & ~ext_irq0_vector_ack) | edge0) : ~ext_irq0_pin;
    timer_control_next[`DTC_IE1] = timer_control_reg[`DTC_IT1] ?
      ((timer_control_sw[`DTC_IE1] & ~ext_irq1_vector_ack) | edge1) : ~ext_irq1_pin;
    // Mode and clock select registers.
    timer_mode_control_next = wr_hit(sfr_req, `DTC_ADDR_TIMER_MODE_CONTROL) ? sfr_req.wdata : timer_mode_control_reg;
    t0m_next = wr_hit(sfr_req, `DTC_ADDR_CKCON) ? sfr_req.wdata[`DTC_CK_T0M] : t0m_reg;
    t1m_next = wr_hit(sfr_req, `DTC_ADDR_CKCON) ? sfr_req.wdata[`DTC_CK_T1M] : t1m_reg;
  end

  // Registers control state and counts; frozen while inactive.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      timer_control_reg <= `DTC_RST_BYTE;
      timer_mode_control_reg <= `DTC_RST_BYTE;
      t0m_reg <= 1'h0;
      t1m_reg <= 1'h0;
      tl0_reg <= `DTC_RST_BYTE;
      th0_reg <= `DTC_RST_BYTE;
      tl1_reg <= `DTC_RST_BYTE;
      th1_reg <= `DTC_RST_BYTE;
    end
    else if (active)
    begin
      timer_control_reg <= timer_control_next;
      timer_mode_control_reg <= timer_mode_control_next;
      t0m_reg <= t0m_next;
      t1m_reg <= t1m_next;
      tl0_reg <= tl0_next;
      th0_reg <= th0_next;
      tl1_reg <= tl1_next;
      th1_reg <= th1_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.

  // Selects the addressed register; unused bits and locations read high.
  always_comb
  begin
    sfr_rdata_next = sfr_rdata_reg;
    if (sfr_req.rd)
    begin
      case (sfr_req.addr)
        `DTC_ADDR_TIMER_CONTROL: sfr_rdata_next = timer_control_reg;
        `DTC_ADDR_TIMER_MODE_CONTROL: sfr_rdata_next = timer_mode_control_reg;
        `DTC_ADDR_TL0: sfr_rdata_next = tl0_reg;
        `DTC_ADDR_TL1: sfr_rdata_next = tl1_reg;
        `DTC_ADDR_TH0: sfr_rdata_next = th0_reg;
        `DTC_ADDR_TH1: sfr_rdata_next = th1_reg;
        `DTC_ADDR_CKCON: sfr_rdata_next = {3'h7, t1m_reg, t0m_reg, 3'h7};
        default: sfr_rdata_next = `DTC_UNMAPPED;
      endcase
    end
  end

  // Registers the read data.
  always_ff @(posedge clk)
  begin
    if (reset)
      sfr_rdata_reg <= `DTC_UNMAPPED;
    else if (active)
      sfr_rdata_reg <= sfr_rdata_next;
  end

  // Outputs straight from flip-flops.
  assign sfr_rdata = sfr_rdata_reg;
  assign timer0_overflow_flag = timer_control_reg[`DTC_TF0];
  assign timer1_overflow_flag = timer_control_reg[`DTC_TF1];
  assign ext_irq0_flag = timer_control_reg[`DTC_IE0];
  assign ext_irq1_flag = timer_control_reg[`DTC_IE1];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking dtc_cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Overflow and vectoring of timer 0.
  chk_tf_overflow_set: assert property (active && ovf0 |=> timer0_overflow_flag)
    else $error("timer 0 overflow did not set its flag");
  chk_tf_vector_clear: assert property (
    active && timer0_vector_ack && !ovf0 |=> !timer0_overflow_flag)
    else $error("timer 0 flag not cleared on vector");
  // Stopped or gated timer holds its low byte.
  chk_run_bit_hold: assert property (
    active && !timer_control_reg[`DTC_TR0] && !wr_hit(sfr_req, `DTC_ADDR_TL0) |=> $stable(tl0_reg))
    else $error("timer 0 advanced with run bit clear");
  chk_gate_pin_hold: assert property (
    active && t0f.gate && !ext_irq0_pin && !wr_hit(sfr_req, `DTC_ADDR_TL0)
    |=> $stable(tl0_reg))
    else $error("gated timer 0 advanced with pin low");
  // Counter mode steps once per falling pin edge.
  chk_count_pin_edge: assert property (
    active && run_en0 && t0f.count_sel && t0f.mode == dtc_pkg::DTC_MODE_16BIT &&
    t0_prev_reg && !timer0_count_pin && !wr_hit(sfr_req, `DTC_ADDR_TL0)
    |=> tl0_reg == $past(tl0_reg) + 8'h01)
    else $error("counter mode missed a falling edge");
  chk_reload_value: assert property (
    active && inc0 && t0f.mode == dtc_pkg::DTC_MODE_RELOAD && tl0_reg == 8'hFF &&
    !wr_hit(sfr_req, `DTC_ADDR_TL0) |=> tl0_reg == $past(th0_reg))
    else $error("mode 2 reload value wrong");
  chk_t1_split_hold: assert property (
    active && t1f.mode == dtc_pkg::DTC_MODE_SPLIT && !wr_hit(sfr_req, `DTC_ADDR_TL1) &&
    !wr_hit(sfr_req, `DTC_ADDR_TH1) |=> $stable(tl1_reg) && $stable(th1_reg))
    else $error("timer 1 advanced in mode 3");
  chk_ext_level_follow: assert property (
    active && !timer_control_reg[`DTC_IT0] |=> ext_irq0_flag == !$past(ext_irq0_pin))
    else $error("level flag does not follow pin");
  chk_ext_edge_set: assert property (
    active && timer_control_reg[`DTC_IT0] && irq0_prev_reg && !ext_irq0_pin |=> ext_irq0_flag)
    else $error("falling edge did not set flag");
  chk_powerdown_hold: assert property (
    power_down_request |=> $stable(tl0_reg) && $stable(th1_reg) && $stable(timer_control_reg))
    else $error("state changed in power down");
  chk_unmapped_ones: assert property (
    active && sfr_req.rd && !is_mapped(sfr_req.addr) |=> sfr_rdata == `DTC_UNMAPPED)
    else $error("unmapped read not all ones");

  // Main scenarios.
  cov_t0_overflow: cover property (active && ovf0 ##1 timer0_overflow_flag);
  cov_reload: cover property (active && inc0 && t0f.mode == dtc_pkg::DTC_MODE_RELOAD && ovf0);
  cov_split_high: cover property (active && th0_inc && th0_sum[8]);

endmodule // dtc_timers

// >>> sim/dtc_pin_model.sv
/*
  Pin-side model of the dual timer block: both interrupt pins and both count pins.
  Assumes the bench calls its tasks just after a rising edge of clk.
*/
`timescale 1ns/1ps

module dtc_pin_model (
  // Clock.
  input wire logic clk,
  // Pins towards the block.
  output logic ext_irq0_pin,
  output logic ext_irq1_pin,
  output logic timer0_count_pin,
  output logic timer1_count_pin
);

  ////////////////////////////////////////////////////////////////////////////////////////
  // The port pins have pull-ups, so every pin rests high when nothing pulls it.
  initial
  begin
    ext_irq0_pin = 1'b1;
    ext_irq1_pin = 1'b1;
    timer0_count_pin = 1'b1;
    timer1_count_pin = 1'b1;
  end

  // Drives both interrupt pins, which are also the gate inputs, to one level.
  task automatic set_irq(input logic lvl);
    ext_irq0_pin <= lvl;
    ext_irq1_pin <= lvl;
  endtask

  // Sends n falling edges on both count pins, one cycle low and one cycle high each.
  task automatic pulse(input int n);
    repeat (n)
    begin
      timer0_count_pin <= 1'b0;
      timer1_count_pin <= 1'b0;
      @(posedge clk);
      timer0_count_pin <= 1'b1;
      timer1_count_pin <= 1'b1;
      @(posedge clk);
    end
  endtask

endmodule // dtc_pin_model

// >>> sim/testbench.sv
/*
  Self-checking bench of the dual timer block: registers, bit writes, modes, gating, freeze.
  Assumes read data answers one cycle after the taken edge and the pin model drives the pins.
*/
`timescale 1ns/1ps
`include "dtc_cfg.svh"

module testbench;

  // One timed case: setup, pin level, window, freeze kind and expected results.
  typedef struct {
    logic [7:0] timer_mode_control, ck, tl0, th0, tl1, th1, run;
    logic pin;
    int win, pul, frz;
    logic [7:0] e0, eh0, e1, eh1, tc;
  } dtc_case_type;

  logic clk, reset, clk_en, power_down_request;
  dtc_pkg::dtc_sfr_req_type req;
  logic [7:0] sfr_rdata, v;
  logic [3:0] ack;
  logic irq0_pin, irq1_pin, cnt0_pin, cnt1_pin;
  logic [7:0] exp_q[$];
  logic rd_pipe;
  int bad_count, checks_done, cycles;
  int seed = 32'h298227F6;
  dtc_case_type c;
  logic [7:0] rst_val[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE7, 8'hFF, 8'hFF};
  dtc_case_type cases[12] = '{
    '{8'h11, 8'h18, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h50, 1, 8, 0, 0, 8'h01, 8'h00, 8'h01, 8'h00, 8'hF0},
    '{8'h11, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h50, 1, 24, 0, 0, 8'h01, 8'h00, 8'h01, 8'h00, 8'hF0},
    '{8'h00, 8'h18, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h50, 1, 8, 0, 0, 8'hE1, 8'h00, 8'h21, 8'h00, 8'hF0},
    '{8'h22, 8'h18, 8'hFF, 8'hA5, 8'hFF, 8'h5A, 8'h50, 1, 8, 0, 0, 8'hA6, 8'hA5, 8'h5B, 8'h5A, 8'hF0},
    '{8'h33, 8'h18, 8'hFF, 8'hFF, 8'h77, 8'h88, 8'h50, 1, 8, 0, 0, 8'h01, 8'h01, 8'h77, 8'h88, 8'hF0},
    '{8'h99, 8'h18, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h50, 0, 8, 0, 0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h5A},
    '{8'h99, 8'h18, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h50, 1, 8, 0, 0, 8'h01, 8'h00, 8'h01, 8'h00, 8'hF0},
    '{8'h11, 8'h18, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h50, 0, 8, 0, 0, 8'h01, 8'h00, 8'h01, 8'h00, 8'hFA},
    '{8'h55, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h50, 1, 24, 3, 0, 8'h02, 8'h00, 8'h02, 8'h00, 8'hF0},
    '{8'h11, 8'h18, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 1, 8, 0, 0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00},
    '{8'h11, 8'h18, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h50, 1, 8, 0, 1, 8'h01, 8'h00, 8'h01, 8'h00, 8'hF0},
    '{8'h11, 8'h18, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h50, 1, 8, 0, 2, 8'h01, 8'h00, 8'h01, 8'h00, 8'hF0}
  };

  ////////////////////////////////////////////////////////////////////////////////////////
  // The block under test and the pin model.
  dtc_timers dut (
    .clk(clk), .reset(reset), .clk_en(clk_en), .power_down_request(power_down_request),
    .sfr_req(req), .sfr_rdata(sfr_rdata),
    .timer0_vector_ack(ack[0]), .timer1_vector_ack(ack[1]),
    .ext_irq0_vector_ack(ack[2]), .ext_irq1_vector_ack(ack[3]),
    .ext_irq0_pin(irq0_pin), .ext_irq1_pin(irq1_pin),
    .timer0_count_pin(cnt0_pin), .timer1_count_pin(cnt1_pin),
    .timer0_overflow_flag(), .timer1_overflow_flag(), .ext_irq0_flag(), .ext_irq1_flag()
  );
  dtc_pin_model pins (
    .clk(clk), .ext_irq0_pin(irq0_pin), .ext_irq1_pin(irq1_pin),
    .timer0_count_pin(cnt0_pin), .timer1_count_pin(cnt1_pin)
  );

  // The 10 MHz system clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    checks_done++;
    if (seen !== expv)
    begin
      bad_count++;
      $display("[ERR] %0t ns: read %h, expected %h", $time, seen, expv);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Holds one request until the edge that takes it; k is bit write, write, read.
  task automatic bus(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d);
    req <= '{rd: k[0], wr: k[1], addr: a, wdata: d, bit_wr: k[2], bit_addr: a, bit_val: d[0]};
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(3'b010, a, d);
  endtask

  // A read notes its expected answer before it goes out.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(3'b001, a, 8'h00);
  endtask

  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse_ack(input logic [3:0] k);
    req <= '0;
    ack <= k;
    @(posedge clk);
    ack <= 4'h0;
  endtask

  // Keeps a timer window of win active edges, frozen for 20 cycles if asked.
  task automatic hold(input int win, input int frz);
    idle(2);
    if (frz == 1)
      power_down_request <= 1'b1;
    if (frz == 2)
      clk_en <= 1'b0;
    if (frz != 0)
    begin
      repeat (20) @(posedge clk);
      power_down_request <= 1'b0;
      clk_en <= 1'b1;
    end
    idle(win - 4);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Takes the oldest note at the edge after the taken edge, before the next read replaces it.
  always @(posedge clk)
  begin
    rd_pipe <= req.rd & clk_en & ~power_down_request;
    if (rd_pipe)
      check(sfr_rdata, exp_q.pop_front());
  end

  // Cuts a hang short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      bad_count++;
      $display("[ERR] %0t ns: run took too long", $time);
      give_verdict();
    end
  end

  // Main sequence.
  initial
  begin
    req = '0;
    ack = 4'h0;
    rd_pipe = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    power_down_request = 1'b0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++)
      rd(8'(8'h88 + i), rst_val[i]);
    for (int i = 10; i < 14; i++)
    begin
      v = 8'($random(seed));
      wr(8'(8'h80 + i), v);
      rd(8'(8'h80 + i), v);
    end
    wr(`DTC_ADDR_CKCON, 8'hFF);
    rd(`DTC_ADDR_CKCON, 8'hFF);
    wr(`DTC_ADDR_CKCON, 8'h00);
    rd(`DTC_ADDR_CKCON, 8'hE7);
    wr(8'h90, 8'h55);
    rd(8'h90, 8'hFF);
    $display("test registers done");
    // Software sets each overflow flag by bit write and the vector clears it.
    for (int i = 0; i < 2; i++)
    begin
      bus(3'b100, i ? 8'h8F : 8'h8D, 8'h01);
      rd(`DTC_ADDR_TIMER_CONTROL, i ? 8'h80 : 8'h20);
      pulse_ack(i ? 4'h2 : 4'h1);
      rd(`DTC_ADDR_TIMER_CONTROL, 8'h00);
    end
    bus(3'b100, 8'h97, 8'h01);
    rd(`DTC_ADDR_TIMER_CONTROL, 8'h00);
    $display("test bit writes done");
    // Timed windows: each case sets up both timers and waits a known count of active edges.
    foreach (cases[i])
    begin
      c = cases[i];
      wr(`DTC_ADDR_TIMER_MODE_CONTROL, c.timer_mode_control);
      wr(`DTC_ADDR_CKCON, c.ck);
      wr(`DTC_ADDR_TL0, c.tl0);
      wr(`DTC_ADDR_TH0, c.th0);
      wr(`DTC_ADDR_TL1, c.tl1);
      wr(`DTC_ADDR_TH1, c.th1);
      pins.set_irq(c.pin);
      wr(`DTC_ADDR_TIMER_CONTROL, c.run);
      fork
        pins.pulse(c.pul);
        hold(c.win, c.frz);
      join
      rd(`DTC_ADDR_TIMER_CONTROL, c.tc);
      wr(`DTC_ADDR_TIMER_CONTROL, 8'h00);
      rd(`DTC_ADDR_TL0, c.e0);
      rd(`DTC_ADDR_TH0, c.eh0);
      rd(`DTC_ADDR_TL1, c.e1);
      rd(`DTC_ADDR_TH1, c.eh1);
      $display("test timer case %0d done", i);
    end
    // External flags: falling edge mode, then low level mode.
    wr(`DTC_ADDR_TIMER_CONTROL, 8'h05);
    pins.set_irq(1'b0);
    idle(1);
    rd(`DTC_ADDR_TIMER_CONTROL, 8'h0F);
    pulse_ack(4'hC);
    rd(`DTC_ADDR_TIMER_CONTROL, 8'h05);
    pins.set_irq(1'b1);
    idle(2);
    rd(`DTC_ADDR_TIMER_CONTROL, 8'h05);
    wr(`DTC_ADDR_TIMER_CONTROL, 8'h00);
    pins.set_irq(1'b0);
    idle(2);
    rd(`DTC_ADDR_TIMER_CONTROL, 8'h0A);
    pulse_ack(4'hC);
    idle(1);
    rd(`DTC_ADDR_TIMER_CONTROL, 8'h0A);
    pins.set_irq(1'b1);
    idle(2);
    rd(`DTC_ADDR_TIMER_CONTROL, 8'h00);
    idle(3);
    $display("test external flags done");
    give_verdict();
  end

endmodule // testbench
